// >>> rtl/dtrg_pkg.sv
// Package for the debug trigger and run status logic
`default_nettype none
package dtrg_pkg;
   // Register offsets on the plain port
   localparam logic [3:0] TRIG_CFG_OFS = 4'h0;
   localparam logic [3:0] RUN_STAT_OFS = 4'h1;
   localparam logic [3:0] DBG_CTRL_OFS = 4'h2;
   // Trigger configuration fields
   localparam int EXEC_QUAL_BIT = 7;
   localparam int START_ON_TRIG_BIT = 6;
   localparam logic [7:0] TRIG_CFG_WMASK = 8'hCF;
   localparam logic [7:0] TRIG_CFG_RST = 8'h00;
   // Status fields
   localparam int MATCH_A_BIT = 7;
   localparam int MATCH_B_BIT = 6;
   localparam int RUN_ACTIVE_BIT = 5;
   // Control fields
   localparam int ENABLE_BIT = 7;
   localparam int ARM_BIT = 6;
   localparam int BREAK_EN_BIT = 4;
   localparam logic [7:0] DBG_CTRL_RST = 8'h00;
   localparam logic [3:0] FIFO_DEPTH = 4'h8;
   // Trigger modes
   typedef enum logic [3:0] {
      TM_A_ONLY = 4'h0,
      TM_A_OR_B = 4'h1,
      TM_A_THEN_B = 4'h2,
      TM_EVT_B = 4'h3,
      TM_A_THEN_EVT_B = 4'h4,
      TM_A_AND_B = 4'h5,
      TM_A_NOT_B = 4'h6,
      TM_INSIDE = 4'h7,
      TM_OUTSIDE = 4'h8
   } dtrg_mode_t;
   // Comparator side inputs
   typedef struct packed {
      logic matchA;
      logic matchB;
      logic execA;
      logic execB;
      logic geA;
      logic leB;
   } dtrg_cmp_t;
   // Register port request
   typedef struct packed {
      logic [3:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } dtrg_bus_t;
endpackage : dtrg_pkg
`default_nettype wire

// >>> rtl/dtrg_top.sv
// Debug trigger configuration and run status logic
//
// Chosen here: the strobed register port and the register addresses.
`default_nettype none
// Notes on behaviour
// - Trigger config always readable, writes ignored while the arm bit is set.
// - Trigger config bits 4 and 5 read zero.
// - Bit 7 set: match counts only if opcode executes; clear: any access.
// - Bit 6: 0 end trace circular, 1 trigger begins storage.
// - Event-only modes ignore bit 6 and act as begin trace.
// - Modes 0..6: A, A or B, A then B, evt B, A then evt B, A and B, A not B.
// - Mode 7 inside A..B inclusive, mode 8 outside.
// - Modes 9..15 never trigger.
// - Run status read only; writes have no effect.
// - Match A flag clears at run start, sets on A match while armed.
// - Match B flag clears at run start, sets on B match while armed.
// - Armed flag mirrors arm bit while enabled.
// - Writing arm 1 while enabled sets armed flag.
// - Run ends on FIFO full in begin trace or trigger in end trace.
// - Writing 0 to arm or enable ends a run.
// - Valid count clears at run start, holds 0..8 words at run end.
// - Valid count does not decrement on FIFO reads.
// - Break on trigger for end trace, on FIFO full for begin trace.
// - Enable cannot be set while secured.
module dtrg_top (
   // Clock and reset
   input wire logic mclk,
   input wire logic rstn,
   // Register port
   input wire dtrg_pkg::dtrg_bus_t bus,
   output logic [7:0] rdata,
   // Comparators and chip state
   input wire dtrg_pkg::dtrg_cmp_t cmp,
   input wire logic secured,
   // FIFO side
   input wire logic fifoStore,
   output logic captureOn,
   output logic storeEn,
   output logic breakReq
);
   import dtrg_pkg::*;

   logic [7:0] trigCfg;
   logic [7:0] ctrl;
   logic matchA;
   logic matchB;
   logic seenA;
   logic [3:0] cnt;
   logic armed;
   logic beginTrace;
   logic evtMode;
   logic qA;
   logic qB;
   logic trig;
   logic fifoFull;
   logic runEnd;
   logic started;
   logic ctrlWr;
   logic [3:0] mode;

   assign ctrlWr = bus.wr && bus.addr == DBG_CTRL_OFS;
   assign armed = ctrl[ARM_BIT] && ctrl[ENABLE_BIT];
   assign mode = trigCfg[3:0];
   assign evtMode = mode == TM_EVT_B || mode == TM_A_THEN_EVT_B;
   assign beginTrace = evtMode || trigCfg[START_ON_TRIG_BIT];
   // Qualified matches
   assign qA = trigCfg[EXEC_QUAL_BIT] ? cmp.execA : cmp.matchA;
   assign qB = trigCfg[EXEC_QUAL_BIT] ? cmp.execB : cmp.matchB;
   assign fifoFull = cnt == FIFO_DEPTH;
   assign started = ctrlWr && bus.wdata[ARM_BIT] && bus.wdata[ENABLE_BIT] && !secured;

   // Trigger decode
   always_comb begin
      case (mode)
         TM_A_ONLY: trig = qA;
         TM_A_OR_B: trig = qA || qB;
         TM_A_THEN_B: trig = seenA && qB;
         TM_EVT_B: trig = qB;
         TM_A_THEN_EVT_B: trig = seenA && qB;
         TM_A_AND_B: trig = qA && qB;
         TM_A_NOT_B: trig = qA && !qB;
         TM_INSIDE: trig = cmp.geA && cmp.leB;
         TM_OUTSIDE: trig = !cmp.geA || !cmp.leB;
         default: trig = 1'b0;
      endcase
   end

   assign runEnd = armed && (beginTrace ? fifoFull : trig);

   // Trigger configuration register
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         trigCfg <= TRIG_CFG_RST;
      end else if (bus.wr && bus.addr == TRIG_CFG_OFS && !ctrl[ARM_BIT]) begin
         trigCfg <= bus.wdata & TRIG_CFG_WMASK;
      end
   end

   // Control register
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         ctrl <= DBG_CTRL_RST;
      end else if (ctrlWr) begin
         ctrl <= bus.wdata;
         ctrl[ENABLE_BIT] <= bus.wdata[ENABLE_BIT] && !secured;
      end else if (runEnd) begin
         ctrl[ARM_BIT] <= 1'b0;
      end
   end

   // A then B sequencing
   always_ff @(posedge mclk) begin
      if (!rstn || started) begin
         seenA <= 1'b0;
      end else if (armed && qA) begin
         seenA <= 1'b1;
      end
   end

   // Match flags, only hardware changes them
   always_ff @(posedge mclk) begin
      if (!rstn || started) begin
         matchA <= 1'b0;
         matchB <= 1'b0;
      end else if (armed) begin
         if (qA) matchA <= 1'b1;
         if (qB) matchB <= 1'b1;
      end
   end

   // Valid word count, blind to FIFO reads
   always_ff @(posedge mclk) begin
      if (!rstn || started) begin
         cnt <= 4'h0;
      end else if (armed && fifoStore && !fifoFull) begin
         cnt <= cnt + 4'h1;
      end
   end

   // Capture gating and break
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         captureOn <= 1'b0;
         storeEn <= 1'b0;
         breakReq <= 1'b0;
      end else begin
         captureOn <= armed && !runEnd;
         if (started || !armed || runEnd) begin
            storeEn <= 1'b0;
         end else if (!beginTrace || trig) begin
            storeEn <= 1'b1;
         end
         breakReq <= runEnd && ctrl[BREAK_EN_BIT];
      end
   end

   // Read data
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         rdata <= 8'h00;
      end else if (bus.rd) begin
         if (bus.addr == TRIG_CFG_OFS) begin
            rdata <= trigCfg;
         end else if (bus.addr == RUN_STAT_OFS) begin
            rdata <= {matchA, matchB, armed, 1'b0, cnt};
         end else if (bus.addr == DBG_CTRL_OFS) begin
            rdata <= ctrl;
         end else begin
            rdata <= 8'h00;
         end
      end else begin
         rdata <= 8'h00;
      end
   end
endmodule : dtrg_top
`default_nettype wire

// >>> tb/dtrg_monitor.sv
// Assertion checker for the debug trigger and run status logic
`default_nettype none
module dtrg_monitor (
   // Ports of the block
   input wire logic mclk,
   input wire logic rstn,
   input wire dtrg_pkg::dtrg_bus_t bus,
   input wire logic [7:0] rdata,
   input wire dtrg_pkg::dtrg_cmp_t cmp,
   input wire logic secured,
   input wire logic captureOn,
   input wire logic storeEn,
   input wire logic breakReq
);
   import dtrg_pkg::*;
   default clocking @(posedge mclk); endclocking
   default disable iff (!rstn);
   sequence ctlWr; bus.wr && bus.addr == DBG_CTRL_OFS; endsequence
   cfg_zero_a: assert property (bus.rd && bus.addr == TRIG_CFG_OFS |=> rdata[5:4] == 2'b00)
      else $error("trigger config bits 5:4 not zero");
   stat_count_a: assert property (bus.rd && bus.addr == RUN_STAT_OFS |=> rdata[3:0] <= 4'h8)
      else $error("valid count above eight");
   arm_go_a: assert property (ctlWr ##0 bus.wdata[7:6] == 2'b11 && !secured && cmp == '0
      ##1 cmp == '0 |-> ##[0:1] captureOn) else $error("run did not start");
   run_stop_a: assert property (ctlWr ##0 !bus.wdata[6] |-> ##[1:2] !captureOn)
      else $error("run did not stop");
   secure_a: assert property (ctlWr ##0 secured |-> ##[1:2] !captureOn)
      else $error("run started while secured");
   brk_pulse_a: assert property (breakReq |=> !breakReq)
      else $error("break request longer than one cycle");
   wr_quiet_a: assert property (bus.wr |=> rdata == 8'h00)
      else $error("write produced read data");
   reset_zero_a: assert property ($past(!rstn) |-> !captureOn && !storeEn && !breakReq)
      else $error("outputs not clear after reset");
endmodule : dtrg_monitor
bind dtrg_top dtrg_monitor dtrg_monitor_inst (.*);
`default_nettype wire

// >>> tb/dtrg_fifo_model.sv
// Model of the capture FIFO facing the block
`default_nettype none
module dtrg_fifo_model (
   // Clock and control
   input wire logic mclk,
   input wire logic clr,
   input wire logic stall,
   // Store path
   input wire logic storeEn,
   output logic fifoStore,
   output int words
);
   timeunit 1ns;
   timeprecision 1ps;
   assign fifoStore = storeEn && !stall;
   initial words = 0;
   always @(posedge mclk) begin
      if (clr) words <= 0;
      else if (fifoStore) words <= words + 1;
   end
endmodule : dtrg_fifo_model
`default_nettype wire

// >>> tb/dtrg_top_tb_top.sv
// Testbench for the debug trigger and run status logic
`default_nettype none
module dtrg_top_tb_top;
   import dtrg_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic mclk = 0, rstn = 0, secured = 0, clr = 0, stall = 0;
   logic fifoStore, captureOn, storeEn, breakReq;
   logic [7:0] rdata, r;
   dtrg_bus_t bus = '0;
   dtrg_cmp_t cmp = '0;
   int err_count = 0, checked = 0, cyc = 0, seed = 32'h25dd, brks = 0;
   int words;
   dtrg_top dtrg_top_inst (
      .mclk(mclk),
      .rstn(rstn),
      .bus(bus),
      .rdata(rdata),
      .cmp(cmp),
      .secured(secured),
      .fifoStore(fifoStore),
      .captureOn(captureOn),
      .storeEn(storeEn),
      .breakReq(breakReq)
   );
   dtrg_fifo_model dtrg_fifo_model_inst (
      .mclk(mclk),
      .clr(clr),
      .stall(stall),
      .storeEn(storeEn),
      .fifoStore(fifoStore),
      .words(words)
   );
   // Break pulses seen so far
   always @(posedge mclk) begin
      if (breakReq === 1'b1) brks++;
   end
   initial forever #4 mclk = ~mclk;
   always @(posedge mclk) begin
      stall <= ($random(seed) % 3) == 0;
      cyc++;
      if (cyc == 6000) begin
         err_count++;
         stop_test();
      end
   end
   task automatic stop_test();
      $display("checked %0d mismatches %0d", checked, err_count);
      if (err_count == 0 && checked > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : stop_test
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge mclk);
      bus <= {a, d, 2'b10};
      @(posedge mclk);
      bus.wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [3:0] a, input logic [7:0] e, input logic [7:0] m);
      @(posedge mclk);
      bus <= {a, 8'h00, 2'b01};
      @(posedge mclk);
      bus.rd <= 1'b0;
      #1 checked++;
      if ((rdata & m) !== (e & m)) begin
         err_count++;
         $display("wrong value at %0t: reg %0d read %h", $time, a, rdata);
      end
   endtask : rd
   task automatic run(input logic [7:0] c, input dtrg_cmp_t t, input logic [7:0] e, m);
      wr(0, c);
      clr <= 1'b1;
      wr(2, 8'hD0);
      clr <= 1'b0;
      @(posedge mclk);
      cmp <= t;
      @(posedge mclk);
      cmp <= '0;
      for (int i = 0; i < 60 && captureOn; i++) @(posedge mclk);
      repeat (4) @(posedge mclk);
      rd(1, e | (words > 8 ? 8'h08 : 8'(words)), m);
      $display("test done at %0t", $time);
   endtask : run
   initial begin
      repeat (16) @(posedge mclk);
      rstn <= 1'b1;
      rd(0, 8'h00, 8'hFF);
      rd(1, 8'h00, 8'hFF);
      for (int i = 0; i < 4; i++) begin
         r = 8'($random(seed));
         wr(0, r);
         rd(0, r & 8'hCF, 8'hFF);
      end
      run(8'h00, 6'h20, 8'h80, 8'hFF);
      run(8'h01, 6'h10, 8'h40, 8'hFF);
      checked++;
      if (brks !== 2) begin
         err_count++;
         $display("wrong value at %0t: break pulses %0d", $time, brks);
      end
      for (logic [7:0] m = 8'h09; m < 8'h10; m++) begin
         run(m, 6'h3F, 8'h20, 8'h20);
         wr(0, 8'h00);
         wr(2, 8'h80);
         rd(1, 8'h00, 8'h20);
         rd(0, m, 8'hFF);
      end
      run(8'h80, 6'h20, 8'h20, 8'hE0);
      @(posedge mclk);
      cmp <= 6'h28;
      @(posedge mclk);
      cmp <= '0;
      rd(1, 8'h80, 8'hE0);
      run(8'h40, 6'h20, 8'h88, 8'hFF);
      rd(1, 8'h88, 8'hFF);
      wr(1, 8'hFF);
      rd(1, 8'h88, 8'hFF);
      @(posedge mclk);
      secured <= 1'b1;
      run(8'h00, '0, 8'h00, 8'h20);
      stop_test();
   end
endmodule : dtrg_top_tb_top
`default_nettype wire
